// ---- logic/rco_pkg.sv ----
`default_nettype none
package rco_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned DIV_W  = 15;
  localparam int unsigned SEL_W  = 4;

  // register word offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL_LOW  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL_HIGH = 4'h4;

  // refclk_control_low field positions, plus DIV_LSB of the high register
  localparam int unsigned BIT_ENABLE     = 15;
  localparam int unsigned BIT_IDLE_STOP  = 13;
  localparam int unsigned BIT_PIN_DRIVE  = 12;
  localparam int unsigned BIT_SLEEP_RUN  = 11;
  localparam int unsigned BIT_SWITCH_REQ = 9;
  localparam int unsigned BIT_ACTIVE     = 8;
  localparam int unsigned SEL_LSB        = 0;
  localparam int unsigned DIV_LSB        = 0;

  // reset values
  localparam logic [DIV_W-1:0] RST_DIVIDER = 15'h0000;
  localparam logic [SEL_W-1:0] RST_SELECT  = 4'h0;

  // source select codes
  localparam logic [SEL_W-1:0] SRC_SYS_FULL = 4'h0;
  localparam logic [SEL_W-1:0] SRC_SYS_HALF = 4'h1;
  localparam logic [SEL_W-1:0] SRC_PRIMARY  = 4'h2;
  localparam logic [SEL_W-1:0] SRC_FAST_RC  = 4'h3;
  localparam logic [SEL_W-1:0] SRC_LP_RC    = 4'h4;
  localparam logic [SEL_W-1:0] SRC_SECOND   = 4'h5;
  localparam logic [SEL_W-1:0] SRC_PLL      = 4'h6;
  localparam logic [SEL_W-1:0] SRC_EXT_PIN  = 4'h8;

  typedef struct packed {
    logic             refgen_enable;
    logic             refgen_idle_stop;
    logic             refgen_pin_drive;
    logic             refgen_sleep_run;
    logic             divider_switch_request;
    logic [SEL_W-1:0] refgen_source_select;
  } rco_ctrl_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rco_bus_req_t;

  // external source levels, synchronous to the system clock
  typedef struct packed {
    logic primary_oscillator;
    logic fast_rc_oscillator;
    logic low_power_rc_oscillator;
    logic secondary_oscillator;
    logic pll;
    logic external_ref_input;
  } rco_src_t;
endpackage
`default_nettype wire

// ---- logic/rco_src_sel.sv ----
`default_nettype none
module rco_src_sel (
  input  wire logic                      i_sys_clk, // system clock
  input  wire logic                      i_arst_n,  // async reset
  input  wire rco_pkg::rco_src_t         i_src,     // source levels
  input  wire logic [rco_pkg::SEL_W-1:0] i_sel,     // source select
  output logic                           o_lvl,     // selected level
  output logic                           o_tick     // rising edge pulse
);
  logic sys_full;
  logic sys_half;
  logic prev_lvl;
  logic sel_lvl;

  // system clock images; sel 0 follows any system clock switch
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sys_full <= 1'b0;
      sys_half <= 1'b0;
      prev_lvl <= 1'b0;
    end else begin
      sys_full <= ~sys_full;
      sys_half <= sys_half ^ sys_full;
      prev_lvl <= sel_lvl;
    end
  end

  // reserved codes select a quiet source
  always_comb begin
    case (i_sel)
      rco_pkg::SRC_SYS_FULL: sel_lvl = sys_full;
      rco_pkg::SRC_SYS_HALF: sel_lvl = sys_half;
      rco_pkg::SRC_PRIMARY:  sel_lvl = i_src.primary_oscillator;
      rco_pkg::SRC_FAST_RC:  sel_lvl = i_src.fast_rc_oscillator;
      rco_pkg::SRC_LP_RC:    sel_lvl = i_src.low_power_rc_oscillator;
      rco_pkg::SRC_SECOND:   sel_lvl = i_src.secondary_oscillator;
      rco_pkg::SRC_PLL:      sel_lvl = i_src.pll;
      rco_pkg::SRC_EXT_PIN:  sel_lvl = i_src.external_ref_input;
      default:               sel_lvl = 1'b0;
    endcase
  end

  assign o_lvl  = sel_lvl;
  assign o_tick = sel_lvl & ~prev_lvl;
endmodule
`default_nettype wire

// ---- logic/rco_div.sv ----
`default_nettype none
module rco_div (
  input  wire logic                      i_sys_clk, // system clock
  input  wire logic                      i_arst_n,  // async reset
  input  wire logic                      i_run,     // generator running
  input  wire logic                      i_lvl,     // source level
  input  wire logic                      i_tick,    // source rising edge
  input  wire logic [rco_pkg::DIV_W-1:0] i_div,     // half period
  output logic                           o_clk,     // divided clock
  output logic                           o_fall     // high-to-low pulse
);
  logic [rco_pkg::DIV_W-1:0] cnt;
  logic [rco_pkg::DIV_W-1:0] next_cnt;
  logic                      next_clk;
  logic                      wrap;
  logic                      pass;

  assign pass = (i_div == rco_pkg::RST_DIVIDER);
  assign wrap = i_tick & (cnt == i_div - 15'h0001);

  always_comb begin
    next_cnt = cnt;
    next_clk = o_clk;
    if (!i_run) begin
      next_cnt = '0;
      next_clk = 1'b0;
    end else if (pass) begin
      next_cnt = '0;
      next_clk = i_lvl;
    end else if (wrap) begin
      next_cnt = '0;
      next_clk = ~o_clk;
    end else if (i_tick) begin
      next_cnt = cnt + 15'h0001;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt    <= '0;
      o_clk  <= 1'b0;
      o_fall <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      o_clk  <= next_clk;
      o_fall <= o_clk & ~next_clk;
    end
  end
endmodule
`default_nettype wire

// ---- logic/rco_top.sv ----
// Operation
// - The enable bit runs the generator when set, stops it when clear.
// - The divider is the half period in source ticks; zero bypasses it.
// - The switch bit loads a new divider and is cleared by hardware.
// - The 4-bit select picks the source; reserved codes give no clock.
// - The sleep-run bit keeps the generator running in Sleep.
// - The pin-drive bit gates the reference clock onto the pin.
// - The active bit reads one while running and falls after disable.
// - Source code zero follows the system clock through any switch.
// - The half-rate output has its own enable, not the generator's.
// - With the PLL-source bit clear the PLL serves only the reference.
// - The secondary oscillator starts on demand or by its manual bit.
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`default_nettype none
module rco_top (
  input  wire logic                       i_sys_clk,          // 20 MHz clock
  input  wire logic                       i_arst_n,           // async reset
  input  wire rco_pkg::rco_bus_req_t      i_bus,              // register req
  output logic [rco_pkg::DATA_W-1:0]      o_rdata,            // read data
  input  wire rco_pkg::rco_src_t          i_src,              // source levels
  input  wire logic                       i_sleep,            // Sleep mode
  input  wire logic                       i_idle,             // Idle mode
  input  wire logic                       i_half_rate_out_config, // cfg bit
  input  wire logic                       i_pll_ref_source_config, // cfg bit
  input  wire logic                       i_secondary_osc_manual_start, // sw
  output logic                            o_reference_clock_pin, // ref out
  output logic                            o_reference_clock_oe,  // pin oe
  output logic                            o_half_rate_clock_out, // sys/2
  output logic                            o_pll_in_sys_chain,    // pll use
  output logic                            o_secondary_osc_run    // osc on
);
  rco_pkg::rco_ctrl_t        ctrl;
  logic [rco_pkg::DIV_W-1:0] divider;
  logic [rco_pkg::DIV_W-1:0] div_work;
  logic                      running;
  logic                      next_running;
  logic                      want_run;
  logic                      wr_low;
  logic                      wr_high;
  logic                      rd_low;
  logic                      rd_high;
  logic                      sw_take;
  logic                      src_lvl;
  logic                      src_tick;
  logic                      gen_clk;
  logic                      gen_fall;
  logic [rco_pkg::DATA_W-1:0] low_image;
  logic [rco_pkg::DATA_W-1:0] high_image;
  logic [rco_pkg::DATA_W-1:0] next_rdata;

  function automatic logic hit(input logic [rco_pkg::ADDR_W-1:0] a,
                               input logic [rco_pkg::ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wr_low  = i_bus.wr & hit(i_bus.addr, rco_pkg::OFS_CTRL_LOW);
  assign wr_high = i_bus.wr & hit(i_bus.addr, rco_pkg::OFS_CTRL_HIGH);
  assign rd_low  = i_bus.rd & hit(i_bus.addr, rco_pkg::OFS_CTRL_LOW);
  assign rd_high = i_bus.rd & hit(i_bus.addr, rco_pkg::OFS_CTRL_HIGH);

  // run request: enable, minus Sleep and Idle stops
  assign want_run = ctrl.refgen_enable
                  & ~(i_sleep & ~ctrl.refgen_sleep_run)
                  & ~(i_idle & ctrl.refgen_idle_stop);

  // stop only while the output is low, so the last pulse is never cut
  assign next_running = want_run | (running & gen_clk);

  // new divider taken while stopped, at a falling edge of the output, or at once while the working divider is zero
  assign sw_take = ctrl.divider_switch_request
                 & (~running | gen_fall
                    | (div_work == rco_pkg::RST_DIVIDER));

  assign low_image = {ctrl.refgen_enable, 1'b0,
                      ctrl.refgen_idle_stop,
                      ctrl.refgen_pin_drive,
                      ctrl.refgen_sleep_run, 1'b0,
                      ctrl.divider_switch_request,
                      running,
                      4'h0,
                      ctrl.refgen_source_select};
  assign high_image = {1'b0, divider};
  assign next_rdata = rd_low  ? low_image  :
                      rd_high ? high_image : 16'h0000;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl <= '0;
    end else if (wr_low) begin
      ctrl.refgen_enable    <= i_bus.wdata[rco_pkg::BIT_ENABLE];
      ctrl.refgen_idle_stop <= i_bus.wdata[rco_pkg::BIT_IDLE_STOP];
      ctrl.refgen_pin_drive <= i_bus.wdata[rco_pkg::BIT_PIN_DRIVE];
      ctrl.refgen_sleep_run <= i_bus.wdata[rco_pkg::BIT_SLEEP_RUN];
      // software set wins over a hardware clear in the same cycle
      ctrl.divider_switch_request <=
        i_bus.wdata[rco_pkg::BIT_SWITCH_REQ] |
        (ctrl.divider_switch_request & ~sw_take);
      ctrl.refgen_source_select <=
        i_bus.wdata[rco_pkg::SEL_LSB +: rco_pkg::SEL_W];
    end else if (sw_take) begin
      ctrl.divider_switch_request <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      divider  <= rco_pkg::RST_DIVIDER;
      div_work <= rco_pkg::RST_DIVIDER;
    end else begin
      if (wr_high) begin
        divider <= i_bus.wdata[rco_pkg::DIV_LSB +: rco_pkg::DIV_W];
      end
      if (sw_take) begin
        div_work <= divider;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      running               <= 1'b0;
      o_rdata               <= 16'h0000;
      o_reference_clock_pin <= 1'b0;
      o_reference_clock_oe  <= 1'b0;
      o_half_rate_clock_out <= 1'b0;
      o_pll_in_sys_chain    <= 1'b0;
      o_secondary_osc_run   <= 1'b0;
    end else begin
      running               <= next_running;
      o_rdata               <= next_rdata;
      // pin released while drive is off
      o_reference_clock_pin <= gen_clk & ctrl.refgen_pin_drive;
      o_reference_clock_oe  <= ctrl.refgen_pin_drive;
      o_half_rate_clock_out <= i_half_rate_out_config
                             & ~o_half_rate_clock_out;
      o_pll_in_sys_chain    <= i_pll_ref_source_config;
      o_secondary_osc_run   <= i_secondary_osc_manual_start
        | (ctrl.refgen_enable &
           (ctrl.refgen_source_select == rco_pkg::SRC_SECOND));
    end
  end

  // sel 0 images the system clock, so it tracks switches; sel 6 is the
  // PLL tap, which is reference-only while o_pll_in_sys_chain is low
  rco_src_sel u_src_sel (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_src     (i_src),
    .i_sel     (ctrl.refgen_source_select),
    .o_lvl     (src_lvl),
    .o_tick    (src_tick)
  );

  rco_div u_div (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_run     (next_running),
    .i_lvl     (src_lvl),
    .i_tick    (src_tick),
    .i_div     (div_work),
    .o_clk     (gen_clk),
    .o_fall    (gen_fall)
  );
endmodule
`default_nettype wire

// ---- dv/rco_sva.sv ----
`default_nettype none
module rco_sva (
  input wire logic                       i_sys_clk,               // clock
  input wire logic                       i_arst_n,                // reset
  input wire rco_pkg::rco_bus_req_t      i_bus,                   // bus req
  input wire logic [rco_pkg::DATA_W-1:0] o_rdata,                 // rdata
  input wire logic                       i_half_rate_out_config,  // cfg
  input wire logic                       i_pll_ref_source_config, // cfg
  input wire logic                       i_secondary_osc_manual_start, // sw
  input wire logic                       o_reference_clock_pin,   // ref
  input wire logic                       o_reference_clock_oe,    // oe
  input wire logic                       o_half_rate_clock_out,   // sys/2
  input wire logic                       o_pll_in_sys_chain,      // pll
  input wire logic                       o_secondary_osc_run      // osc
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  // bits that must read zero at each address
  logic [15:0] rd_mask;
  assign rd_mask =
    (i_bus.addr == rco_pkg::OFS_CTRL_LOW)  ? 16'h44F0 :
    (i_bus.addr == rco_pkg::OFS_CTRL_HIGH) ? 16'h8000 : 16'hFFFF;
  sequence wr_lo;
    i_bus.wr && i_bus.addr == rco_pkg::OFS_CTRL_LOW;
  endsequence
  sequence rd_lo;
    i_bus.rd && i_bus.addr == rco_pkg::OFS_CTRL_LOW;
  endsequence
  // sampled history, not local variables, so plain simulators take it
  property p_oe;
    wr_lo ##1 !i_bus.wr
      |=> o_reference_clock_oe == $past(i_bus.wdata[12], 2);
  endproperty
  property p_back;
    wr_lo ##2 rd_lo
      |=> (o_rdata & 16'hB80F) == ($past(i_bus.wdata, 3) & 16'hB80F);
  endproperty
  property p_zero;
    i_bus.rd |=> (o_rdata & $past(rd_mask)) == 16'h0000;
  endproperty
  oe_follows_a: assert property (p_oe)
    else $error("pin enable differs from drive bit");
  pin_quiet_a: assert property (
    !o_reference_clock_oe |-> !o_reference_clock_pin)
    else $error("pin active while not driven");
  ctrl_back_a: assert property (p_back)
    else $error("control readback differs");
  unimpl_zero_a: assert property (p_zero)
    else $error("unimplemented bits not zero");
  rd_idle_a: assert property (
    !$past(i_bus.rd) |-> o_rdata == 16'h0000)
    else $error("read data outside read slot");
  half_tog_a: assert property (
    $past(i_half_rate_out_config)
    |-> o_half_rate_clock_out != $past(o_half_rate_clock_out))
    else $error("half rate output not toggling");
  half_off_a: assert property (
    !$past(i_half_rate_out_config) |-> !o_half_rate_clock_out)
    else $error("half rate output runs while off");
  pll_copy_a: assert property (
    $changed(i_pll_ref_source_config)
    |=> (o_pll_in_sys_chain == $past(i_pll_ref_source_config)) [*2])
    else $error("pll chain flag wrong");
  osc_manual_a: assert property (
    i_secondary_osc_manual_start |=> o_secondary_osc_run)
    else $error("manual start ignored");
endmodule
bind rco_top rco_sva rco_sva_inst (.i_sys_clk, .i_arst_n, .i_bus, .o_rdata,
  .i_half_rate_out_config, .i_pll_ref_source_config,
  .i_secondary_osc_manual_start, .o_reference_clock_pin, .o_reference_clock_oe,
  .o_half_rate_clock_out, .o_pll_in_sys_chain, .o_secondary_osc_run);
`default_nettype wire

// ---- dv/rco_ref_sink.sv ----
`default_nettype none
module rco_ref_sink (
  input  wire logic        i_sys_clk, // system clock
  input  wire logic        i_pin,     // reference pin level
  input  wire logic        i_oe,      // pin driven
  output logic      [15:0] o_edges,   // rising edges seen
  output logic      [15:0] o_period   // cycles between rises
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        line;
  logic        last = 1'b0;
  logic [15:0] cnt = 16'h0000;
  // undriven pin rests on its pull-down
  assign line = i_oe & i_pin;
  initial begin
    o_edges = 16'h0000;
    o_period = 16'h0000;
  end
  always @(posedge i_sys_clk) begin
    last <= line;
    cnt <= cnt + 16'h0001;
    if (line && !last) begin
      o_edges <= o_edges + 16'h0001;
      o_period <= cnt + 16'h0001;
      cnt <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk = 1'b0;
  logic                  arst_n = 1'b0;
  rco_pkg::rco_bus_req_t bus = '0;
  logic [15:0]           rdata;
  logic [3:0]            cnt = 4'h0;
  logic                  sleep = 1'b0;
  logic                  idle = 1'b0;
  logic                  half_cfg = 1'b0;
  logic                  pll_cfg = 1'b0;
  logic                  man = 1'b0;
  logic                  pin;
  logic                  oe;
  logic                  half;
  logic                  pll_use;
  logic                  osc_run;
  logic [15:0]           edges;
  logic [15:0]           period;
  int                    n_errors = 0;
  int                    n_compared = 0;
  // control low, divider, sleep/idle, expected period (0 = silent)
  logic [39:0] tab [18] = '{
    40'h9000_01_00_04, 40'h9001_01_00_08, 40'h9002_01_00_04,
    40'h9003_01_00_08, 40'h9004_01_00_10, 40'h9005_01_00_20,
    40'h9006_01_00_08, 40'h9007_01_00_00, 40'h9008_01_00_10,
    40'h9009_01_00_00, 40'h9002_03_00_0C, 40'h9002_00_00_02,
    40'h8002_01_00_00, 40'h1002_01_00_00, 40'h9002_01_10_00,
    40'h9804_01_10_10, 40'hB002_01_01_00, 40'h9002_01_01_04};
  always #25 clk = ~clk;
  always @(posedge clk) cnt <= cnt + 4'h1;
  rco_top rco_top_inst (.i_sys_clk(clk), .i_arst_n(arst_n), .i_bus(bus),
    .o_rdata(rdata), .i_src({cnt[0], cnt[1], cnt[2], cnt[3], cnt[1], cnt[2]}),
    .i_sleep(sleep), .i_idle(idle), .i_half_rate_out_config(half_cfg),
    .i_pll_ref_source_config(pll_cfg), .i_secondary_osc_manual_start(man),
    .o_reference_clock_pin(pin), .o_reference_clock_oe(oe),
    .o_half_rate_clock_out(half), .o_pll_in_sys_chain(pll_use),
    .o_secondary_osc_run(osc_run));
  rco_ref_sink rco_ref_sink_inst (.i_sys_clk(clk), .i_pin(pin), .i_oe(oe),
    .o_edges(edges), .o_period(period));
  task automatic print_verdict;
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // bounded poll of one control low bit; a miss counts, run goes on
  task automatic poll(input int b, input logic v);
    logic [15:0] d;
    d = {16{~v}};
    for (int k = 0; k < 50 && d[b] !== v; k++) rd(rco_pkg::OFS_CTRL_LOW, d);
    chk("status bit", {15'h0000, v}, {15'h0000, d[b]});
  endtask
  initial begin
    logic [15:0] d;
    logic [15:0] cur;
    logic [15:0] e0;
    logic [39:0] t;
    logic        act;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    rd(rco_pkg::OFS_CTRL_LOW, d);
    chk("low reset", 16'h0000, d);
    rd(rco_pkg::OFS_CTRL_HIGH, d);
    chk("high reset", 16'h0000, d);
    wr(rco_pkg::OFS_CTRL_LOW, 16'h44F0);
    rd(rco_pkg::OFS_CTRL_LOW, d);
    chk("low unused", 16'h0000, d);
    wr(rco_pkg::OFS_CTRL_HIGH, 16'hFFFF);
    rd(rco_pkg::OFS_CTRL_HIGH, d);
    chk("high image", 16'h7FFF, d);
    wr(4'h8, 16'hFFFF);
    rd(4'h8, d);
    chk("unmapped", 16'h0000, d);
    cur = 16'h3802;
    wr(rco_pkg::OFS_CTRL_LOW, cur);
    rd(rco_pkg::OFS_CTRL_LOW, d);
    chk("low image", cur, d);
    for (int i = 0; i < 18; i++) begin
      t = tab[i];
      wr(rco_pkg::OFS_CTRL_LOW, cur & 16'h7FFF);
      poll(rco_pkg::BIT_ACTIVE, 1'b0);
      @(posedge clk);
      sleep <= t[12];
      idle <= t[8];
      wr(rco_pkg::OFS_CTRL_HIGH, {8'h00, t[23:16]});
      cur = t[39:24];
      wr(rco_pkg::OFS_CTRL_LOW, cur | 16'h0200);
      poll(rco_pkg::BIT_SWITCH_REQ, 1'b0);
      act = cur[15] & ~(t[12] & ~cur[11]) & ~(t[8] & cur[13]);
      rd(rco_pkg::OFS_CTRL_LOW, d);
      chk("low image", cur | {7'h00, act, 8'h00}, d);
      chk("osc run", {15'h0000, cur[15] && cur[3:0] == 4'h5},
          {15'h0000, osc_run});
      e0 = edges;
      repeat (120) @(posedge clk);
      chk("period", {8'h00, t[7:0]},
          edges == e0 ? 16'h0000 : period);
    end
    wr(rco_pkg::OFS_CTRL_LOW, 16'h0000);
    poll(rco_pkg::BIT_ACTIVE, 1'b0);
    @(posedge clk);
    half_cfg <= 1'b1;
    pll_cfg <= 1'b1;
    man <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("pll use", 16'h0001, {15'h0000, pll_use});
    chk("osc run", 16'h0001, {15'h0000, osc_run});
    d[0] = half;
    @(posedge clk);
    #1;
    chk("half rate", {15'h0000, ~d[0]}, {15'h0000, half});
    print_verdict();
  end
endmodule
`default_nettype wire
